// file: common/tx_end_pkg.sv
// Constants, types and register map of the transmit task end control block
// -----------------------------------------------------------------------------
// What this block does
// - Every task end pulses completion interrupt; reason readable by software.
// - Packet done, repeat setting 0: end with success.
// - Repeat setting 1: empty send queue ends with success, else transmit again.
// - Restart style 1: wait timer event 1, calibrate synthesizer, then transmit.
// - Restart style 0: transmit after programmed wait, calibrating only when time allows.
// - Inter-packet wait counts in 62.5 ns steps.
// - Wait already passed or too short: transmit as early as possible.
// - Power-down or start command while running: abort; radio abort if radio active.
// - Stop during packet or acknowledgment: stopped once both finish.
// - Stop while waiting for timer event 1: end stopped at once.
// - Timer event 2 action: 00/11 nothing, 01 stop, 10 power-down.
// - Retransmissions exhausted without acknowledgment: end with retries-exhausted cause.
// - Send queue empty or broken at packet start: queue error, engine error, radio abort.
// - Receive queue overflow on kept acknowledgment: receive queue error, queue-full interrupt.
// - Unknown command: bad-command end, engine error, radio abort if radio synced.
// - Lock not free at start: end without radio activity, lock cause, engine error.
// - Invalid stored configuration: bad-parameter end with engine error.
// - Length field over 255, 127 or 63 by mode: bad parameter, engine error.
// - Send-when-quiet command: receiver on at channel, sync search off.
// - While listening, sample signal strength every 5.33 us against the limit.
// - More consecutive quiet valid samples than programmed count: start transmitting.
// -----------------------------------------------------------------------------
package tx_end_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_WAIT     = 8'h04;
  localparam logic [7:0] OFS_RETRY    = 8'h08;
  localparam logic [7:0] OFS_CHAN     = 8'h0C;
  localparam logic [7:0] OFS_LIMIT    = 8'h10;
  localparam logic [7:0] OFS_QUIET    = 8'h14;
  localparam logic [7:0] OFS_CMD      = 8'h18;
  localparam logic [7:0] OFS_REASON   = 8'h1C;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  // Control register fields
  localparam int BIT_REPEAT  = 0;
  localparam int BIT_RESTART = 1;
  localparam int LSB_EV2     = 2;
  // Command codes
  localparam logic [7:0] CMD_POWER_DOWN = 8'h01;
  localparam logic [7:0] CMD_STOP       = 8'h02;
  localparam logic [7:0] CMD_SOFT_EVT2  = 8'h03;
  localparam logic [7:0] CMD_SEND       = 8'h81;
  localparam logic [7:0] CMD_SEND_QUIET = 8'h82;
  localparam logic [7:0] CMD_RECEIVE    = 8'h83;
  // Timer event 2 actions
  localparam logic [1:0] EV2_STOP       = 2'h1;
  localparam logic [1:0] EV2_POWER_DOWN = 2'h2;
  // End cause codes
  typedef enum logic [3:0] {
    CAUSE_NONE          = 4'h0,
    CAUSE_SUCCESS       = 4'h1,
    CAUSE_STOPPED       = 4'h2,
    CAUSE_ABORT         = 4'h3,
    CAUSE_RETRIES       = 4'h4,
    CAUSE_SEND_QUEUE    = 4'h5,
    CAUSE_RECEIVE_QUEUE = 4'h6,
    CAUSE_BAD_COMMAND   = 4'h7,
    CAUSE_LOCK_BUSY     = 4'h8,
    CAUSE_BAD_PARAMETER = 4'h9
  } cause_t;
  // Packet outcome reported by the packet engine
  localparam logic [1:0] OUT_DONE     = 2'h0;
  localparam logic [1:0] OUT_RETRIES  = 2'h1;
  localparam logic [1:0] OUT_OVERFLOW = 2'h2;
  // Length limits per framing mode
  localparam logic [1:0] LEN_BASIC  = 2'h0;
  localparam logic [1:0] LEN_AUTO7  = 2'h1;
  localparam logic [7:0] LEN_MAX_BASIC = 8'hFF;
  localparam logic [7:0] LEN_MAX_AUTO7 = 8'h7F;
  localparam logic [7:0] LEN_MAX_AUTO6 = 8'h3F;
  // Timing: clock 10 ns, wait step 62.5 ns, both in half nanoseconds
  localparam int CLK_HALF_NS  = 20;
  localparam int STEP_HALF_NS = 125;
  localparam int CLK_NS       = 10;
  localparam int POLL_NS      = 5330;
  localparam int POLL_CYCLES  = POLL_NS / CLK_NS;
  // Status from the packet engine and radio
  typedef struct packed {
    logic       evt1;        // Timer event 1 pulse
    logic       evt2;        // Timer event 2 pulse
    logic       cal_done;    // Synthesizer calibration finished
    logic       tx_end;      // Last bit of packet sent
    logic       out_valid;   // Packet and acknowledgment handled
    logic [1:0] out_code;    // Outcome of that packet
    logic       q_avail;     // Send queue holds a packet
    logic       q_bad;       // Send queue pointers invalid
    logic       lock_free;   // Lock owned by engine is free
    logic       param_bad;   // Stored configuration invalid
    logic       radio_on;    // Transmitter or receiver running
    logic       synced;      // Receiver has sync
    logic       rssi_valid;  // Signal strength valid
    logic [7:0] rssi;        // Signal strength, signed
    logic [7:0] len_field;   // Length field about to be sent
    logic [1:0] len_mode;    // Framing mode for length limit
  } radio_stat_t;
  // Interrupt pulses
  typedef struct packed {
    logic done;
    logic abort;
    logic eng_err;
    logic rx_full;
  } irq_t;
endpackage : tx_end_pkg

// file: verilog/tx_task_end.sv
// Transmit task continuation, ending and send-when-quiet control with APB registers
//
// Chosen here: the register addresses and the APB register port.
module tx_task_end
  import tx_end_pkg::*;
#(
  parameter int CAL_STEPS = 2400  // Wait steps a synthesizer calibration needs
)(
  input  wire logic        clk_sys,           // System clock, 100 MHz
  input  wire logic        rst_n,             // Asynchronous reset, active low
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB access phase
  input  wire logic        pwrite,            // APB write
  input  wire logic [7:0]  paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error, unmapped
  input  wire radio_stat_t stat,              // Engine and radio status
  output logic             tx_go,             // Start packet pulse
  output logic             cal_go,            // Synthesizer calibration pulse
  output logic             rx_on,             // Receiver enabled for listening
  output logic             sync_search_en,    // Sync search enable
  output logic             rssi_poll,         // Signal strength sample pulse
  output logic [6:0]       channel_frequency, // Channel for the radio
  output logic [7:0]       max_retry_count,   // Retransmission limit
  output logic             task_busy,         // Task running
  output irq_t             irq                // Interrupt pulses
);

  // ---------------------------------------------------------------------------
  // Parameters and state
  // ---------------------------------------------------------------------------
  localparam int PW = $clog2(POLL_CYCLES + 1);

  if (CAL_STEPS < 1 || CAL_STEPS > 65535)
    $error("CAL_STEPS out of range");

  // Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_EVT1   = 3'b001,
    ST_CALIB  = 3'b011,
    ST_LISTEN = 3'b010,
    ST_TX     = 3'b110,
    ST_DELAY  = 3'b111
  } state_t;

  typedef struct packed {
    state_t      st;
    logic        quiet_mode;   // Task listens before each send
    logic        stop_pend;    // Stop seen, waits for packet end
    logic        done_pend;    // Reason written, interrupt next
    logic        repeat_on;
    logic        restart_style;
    logic [1:0]  ev2_action;
    logic [15:0] wait_steps;
    logic [7:0]  retries;
    logic [6:0]  chan;
    logic [7:0]  limit;
    logic [7:0]  quiet_count;
    cause_t      reason;
    logic [7:0]  acc;          // Half-ns residue of the step timer
    logic [15:0] elapsed;      // Steps since last packet end
    logic [PW-1:0] poll_cnt;
    logic [8:0]  quiet_run;
    logic [31:0] rdata;
    logic        tx_go;
    logic        cal_go;
    logic        poll;
    irq_t        irq;
  } regs_t;

  regs_t cur_ff;
  regs_t nxt_cur;

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  logic apb_setup;
  logic apb_wr;
  logic addr_ok;

  // Writes take effect in the access phase, reads are latched in setup
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite && addr_ok;
  // Map is one contiguous run of aligned words
  assign addr_ok   = (paddr <= OFS_STATUS) && (paddr[1:0] == 2'b00);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_ok;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic       cmd_hit;
    logic [7:0] cmd;
    logic       ev2;
    logic       stop_req;
    logic       kill;
    logic       bad_cmd;
    logic       is_start;
    logic       want_tx;
    logic       want_go;
    logic       end_now;
    cause_t     cause;
    logic [7:0] len_max;
    logic [8:0] acc_sum;

    nxt_cur = cur_ff;
    cmd_hit = apb_wr && (paddr == OFS_CMD);
    cmd     = pwdata[7:0];
    want_tx = 1'b0;
    want_go = 1'b0;
    end_now = 1'b0;
    cause   = CAUSE_NONE;
    nxt_cur.tx_go  = 1'b0;
    nxt_cur.cal_go = 1'b0;
    nxt_cur.poll   = 1'b0;
    nxt_cur.irq    = '0;
    // Reason was stored one edge earlier, so it is readable with the pulse
    nxt_cur.irq.done  = cur_ff.done_pend;
    nxt_cur.done_pend = 1'b0;

    // Register writes
    if (apb_wr)
    begin
      case (paddr)
        OFS_CTRL:
        begin
          nxt_cur.repeat_on     = pwdata[BIT_REPEAT];
          nxt_cur.restart_style = pwdata[BIT_RESTART];
          nxt_cur.ev2_action    = pwdata[LSB_EV2 +: 2];
        end
        OFS_WAIT:  nxt_cur.wait_steps  = pwdata[15:0];
        OFS_RETRY: nxt_cur.retries     = pwdata[7:0];
        OFS_CHAN:  nxt_cur.chan        = pwdata[6:0];
        OFS_LIMIT: nxt_cur.limit       = pwdata[7:0];
        OFS_QUIET: nxt_cur.quiet_count = pwdata[7:0];
        default:   nxt_cur.chan        = cur_ff.chan;
      endcase
    end

    // Read data latched in the setup phase
    if (apb_setup)
    begin
      case (paddr)
        OFS_CTRL:   nxt_cur.rdata = {28'h0000000, cur_ff.ev2_action, cur_ff.restart_style,
                                     cur_ff.repeat_on};
        OFS_WAIT:   nxt_cur.rdata = {16'h0000, cur_ff.wait_steps};
        OFS_RETRY:  nxt_cur.rdata = {24'h000000, cur_ff.retries};
        OFS_CHAN:   nxt_cur.rdata = {25'h0, cur_ff.chan};
        OFS_LIMIT:  nxt_cur.rdata = {24'h000000, cur_ff.limit};
        OFS_QUIET:  nxt_cur.rdata = {24'h000000, cur_ff.quiet_count};
        OFS_REASON: nxt_cur.rdata = {28'h0000000, cur_ff.reason};
        OFS_STATUS: nxt_cur.rdata = {26'h0, cur_ff.stop_pend, cur_ff.quiet_mode,
                                     (cur_ff.st != ST_IDLE), cur_ff.st};
        default:    nxt_cur.rdata = 32'h00000000;
      endcase
    end

    // Command and timer event 2 decode
    is_start = cmd_hit && (cmd == CMD_SEND || cmd == CMD_SEND_QUIET || cmd == CMD_RECEIVE);
    ev2      = stat.evt2 || (cmd_hit && cmd == CMD_SOFT_EVT2);
    stop_req = (cmd_hit && cmd == CMD_STOP) || (ev2 && cur_ff.ev2_action == EV2_STOP);
    kill     = (cmd_hit && cmd == CMD_POWER_DOWN)
            || (ev2 && cur_ff.ev2_action == EV2_POWER_DOWN) || is_start;
    bad_cmd  = cmd_hit && !(is_start || cmd == CMD_POWER_DOWN || cmd == CMD_STOP
                            || cmd == CMD_SOFT_EVT2);

    // Step timer in 62.5 ns units, restarted by each packet end
    acc_sum = {1'b0, cur_ff.acc} + 9'(CLK_HALF_NS);
    if (stat.tx_end)
    begin
      nxt_cur.acc     = 8'h00;
      nxt_cur.elapsed = 16'h0000;
    end
    else if (acc_sum >= 9'(STEP_HALF_NS))
    begin
      nxt_cur.acc = 8'(acc_sum - 9'(STEP_HALF_NS));
      if (cur_ff.elapsed != 16'hFFFF)
        nxt_cur.elapsed = cur_ff.elapsed + 16'h0001;
    end
    else
      nxt_cur.acc = acc_sum[7:0];

    if (bad_cmd)
    begin
      // Unknown command ends any task; idle engine reports it too
      end_now = 1'b1;
      cause   = CAUSE_BAD_COMMAND;
      nxt_cur.irq.eng_err = 1'b1;
      nxt_cur.irq.abort   = cur_ff.st != ST_IDLE && stat.radio_on && stat.synced;
    end
    else if (cur_ff.st != ST_IDLE && kill)
    begin
      end_now = 1'b1;
      cause   = CAUSE_ABORT;
      nxt_cur.irq.abort = stat.radio_on;
    end
    else if (stop_req && cur_ff.st != ST_IDLE && cur_ff.st != ST_TX)
    begin
      // Nothing on air outside a packet, so stop ends at once
      end_now = 1'b1;
      cause   = CAUSE_STOPPED;
    end
    else
    begin
      case (cur_ff.st)
        ST_IDLE:
        begin
          if (cmd_hit && (cmd == CMD_SEND || cmd == CMD_SEND_QUIET))
          begin
            nxt_cur.quiet_mode = cmd == CMD_SEND_QUIET;
            nxt_cur.stop_pend  = 1'b0;
            if (!stat.lock_free)
            begin
              end_now = 1'b1;
              cause   = CAUSE_LOCK_BUSY;
              nxt_cur.irq.eng_err = 1'b1;
            end
            else if (stat.param_bad)
            begin
              end_now = 1'b1;
              cause   = CAUSE_BAD_PARAMETER;
              nxt_cur.irq.eng_err = 1'b1;
            end
            else
              nxt_cur.st = ST_EVT1;
          end
        end
        ST_EVT1:
        begin
          if (stat.evt1)
          begin
            nxt_cur.st     = ST_CALIB;
            nxt_cur.cal_go = 1'b1;
          end
        end
        ST_CALIB:
          want_go = stat.cal_done;
        ST_LISTEN:
        begin
          if (cur_ff.poll_cnt == PW'(POLL_CYCLES - 1))
          begin
            nxt_cur.poll_cnt = '0;
            nxt_cur.poll     = 1'b1;
          end
          else
            nxt_cur.poll_cnt = cur_ff.poll_cnt + PW'(1);
          // Sample taken in the cycle of the poll pulse; invalid ones are skipped
          if (cur_ff.poll && stat.rssi_valid)
          begin
            if ($signed(stat.rssi) < $signed(cur_ff.limit))
            begin
              nxt_cur.quiet_run = cur_ff.quiet_run + 9'h001;
              if (cur_ff.quiet_run >= {1'b0, cur_ff.quiet_count})
                want_tx = 1'b1;
            end
            else
              nxt_cur.quiet_run = 9'h000;
          end
        end
        ST_TX:
        begin
          if (stop_req)
            nxt_cur.stop_pend = 1'b1;
          if (stat.out_valid)
          begin
            end_now = 1'b1;
            if (stat.out_code == OUT_RETRIES)
              cause = CAUSE_RETRIES;
            else if (stat.out_code == OUT_OVERFLOW)
            begin
              cause = CAUSE_RECEIVE_QUEUE;
              nxt_cur.irq.rx_full = 1'b1;
            end
            else if (cur_ff.stop_pend || stop_req)
              cause = CAUSE_STOPPED;
            else if (!cur_ff.repeat_on)
              cause = CAUSE_SUCCESS;
            else if (!stat.q_avail)
              cause = CAUSE_SUCCESS;
            else
            begin
              end_now = 1'b0;
              if (cur_ff.restart_style)
                nxt_cur.st = ST_EVT1;
              else
              begin
                nxt_cur.st = ST_DELAY;
                // Calibrate only if the remaining wait covers it
                nxt_cur.cal_go = {1'b0, cur_ff.wait_steps}
                              >= {1'b0, cur_ff.elapsed} + 17'(CAL_STEPS);
              end
            end
          end
        end
        ST_DELAY:
          want_go = cur_ff.elapsed >= cur_ff.wait_steps;
        default: nxt_cur.st = ST_IDLE;
      endcase
    end

    // Calibrated or waited out: quiet tasks listen first, others send
    if (want_go && cur_ff.quiet_mode)
    begin
      nxt_cur.st        = ST_LISTEN;
      nxt_cur.poll_cnt  = '0;
      nxt_cur.quiet_run = 9'h000;
    end
    else if (want_go)
      want_tx = 1'b1;

    // Packet start: queue and length checks
    case (stat.len_mode)
      LEN_BASIC: len_max = LEN_MAX_BASIC;
      LEN_AUTO7: len_max = LEN_MAX_AUTO7;
      default:   len_max = LEN_MAX_AUTO6;
    endcase
    if (want_tx)
    begin
      if (!stat.q_avail || stat.q_bad)
      begin
        end_now = 1'b1;
        cause   = CAUSE_SEND_QUEUE;
        nxt_cur.irq.eng_err = 1'b1;
        nxt_cur.irq.abort   = 1'b1;
      end
      else if (stat.len_field > len_max)
      begin
        end_now = 1'b1;
        cause   = CAUSE_BAD_PARAMETER;
        nxt_cur.irq.eng_err = 1'b1;
      end
      else
      begin
        nxt_cur.st    = ST_TX;
        nxt_cur.tx_go = 1'b1;
      end
    end

    // Task end: reason first, completion pulse one edge later
    if (end_now)
    begin
      nxt_cur.st        = ST_IDLE;
      nxt_cur.reason    = cause;
      nxt_cur.done_pend = 1'b1;
      nxt_cur.stop_pend = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cur_ff <= '{st: ST_IDLE, reason: CAUSE_NONE, default: '0};
    else
      cur_ff <= nxt_cur;
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata            = cur_ff.rdata;
  assign tx_go             = cur_ff.tx_go;
  assign cal_go            = cur_ff.cal_go;
  assign rx_on             = cur_ff.st == ST_LISTEN;
  assign sync_search_en    = 1'b0;
  assign rssi_poll         = cur_ff.poll;
  assign channel_frequency = cur_ff.chan;
  assign max_retry_count   = cur_ff.retries;
  assign task_busy         = cur_ff.st != ST_IDLE;
  assign irq               = cur_ff.irq;

endmodule : tx_task_end

// file: tb/radio_side_model.sv
// Radio and packet engine stand-in beside the block
module radio_side_model
  import tx_end_pkg::*;
(
  input  wire logic        clk_sys, // Clock
  input  wire logic        rst_n,   // Reset
  input  wire logic        cal_go,  // Calibrate
  input  wire logic        tx_go,   // Packet start
  input  wire logic        evt1_en, // Event 1 on
  input  wire radio_stat_t lv,      // Bench levels
  output radio_stat_t      stat     // To block
);
  logic [5:0] tmr_ff;
  logic [2:0] cal_ff;
  logic [4:0] pkt_ff;
  // Packet plus ack wait takes 16 cycles
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tmr_ff <= 6'h00;
      cal_ff <= 3'h0;
      pkt_ff <= 5'h00;
    end
    else
    begin
      tmr_ff <= tmr_ff + 6'h01;
      cal_ff <= cal_go ? 3'h4 : cal_ff - 3'(cal_ff != 3'h0);
      pkt_ff <= tx_go ? 5'h10 : pkt_ff - 5'(pkt_ff != 5'h00);
    end
  end
  // Pulses from counters, levels from bench
  always_comb
  begin
    stat = lv;
    stat.evt1 = evt1_en && (tmr_ff == 6'h00);
    stat.evt2 = 1'b0;
    stat.cal_done = (cal_ff == 3'h1);
    stat.tx_end = (pkt_ff == 5'h05);
    stat.out_valid = (pkt_ff == 5'h01);
  end
endmodule : radio_side_model

// file: tb/tx_task_end_properties.sv
// Port checks for the transmit task end block
module tx_task_end_properties
  import tx_end_pkg::*;
(
  input wire logic        clk_sys,           // Clock
  input wire logic        rst_n,             // Reset
  input wire logic        psel,              // Select
  input wire logic        penable,           // Access
  input wire logic        pwrite,            // Write
  input wire logic [7:0]  paddr,             // Address
  input wire logic [31:0] pwdata,            // Wdata
  input wire radio_stat_t stat,              // Status
  input wire logic        tx_go,             // Send
  input wire logic        cal_go,            // Cal
  input wire logic        rx_on,             // Listen
  input wire logic        sync_search_en,    // Sync
  input wire logic        rssi_poll,         // Sample
  input wire logic        task_busy,         // Busy
  input wire irq_t        irq                // Irqs
);
  logic       cmd_wr;
  logic [9:0] gap_ff;
  logic       had_ff;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  assign cmd_wr = psel && penable && pwrite && (paddr == OFS_CMD);
  // Gap since last sample; first sample of a listen has no gap
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap_ff <= 10'h000;
      had_ff <= 1'b0;
    end
    else
    begin
      gap_ff <= (rssi_poll || !rx_on) ? 10'h000 : gap_ff + 10'h001;
      had_ff <= rx_on && (had_ff || rssi_poll);
    end
  end
  property p_done; $fell(task_busy) |-> ##[0:2] irq.done; endproperty
  a_done: assert property (p_done) else $error("end without done");
  property p_sync; rx_on |-> !sync_search_en; endproperty
  a_sync: assert property (p_sync) else $error("sync on in listen");
  property p_poll; rssi_poll && had_ff |-> gap_ff == 10'(POLL_CYCLES - 1); endproperty
  a_poll: assert property (p_poll) else $error("sample spacing");
  property p_lock; cmd_wr && pwdata[7:0] == CMD_SEND && !task_busy && !stat.lock_free
    |=> irq.eng_err && !tx_go && !cal_go ##1 irq.done && !task_busy; endproperty
  a_lock: assert property (p_lock) else $error("lock busy end");
  property p_abort; cmd_wr && pwdata[7:0] == CMD_POWER_DOWN && task_busy && stat.radio_on
    |=> irq.abort ##1 irq.done; endproperty
  a_abort: assert property (p_abort) else $error("abort end");
  property p_badcmd; cmd_wr && pwdata[7:0] == 8'h55 && task_busy
    |=> irq.eng_err ##1 irq.done; endproperty
  a_badcmd: assert property (p_badcmd) else $error("bad command end");
  property p_retry; stat.out_valid && stat.out_code == OUT_RETRIES && task_busy
    |-> ##2 irq.done; endproperty
  a_retry: assert property (p_retry) else $error("retries end");
  property p_full; stat.out_valid && stat.out_code == OUT_OVERFLOW && task_busy
    |=> irq.rx_full ##1 irq.done; endproperty
  a_full: assert property (p_full) else $error("overflow end");
endmodule : tx_task_end_properties
bind tx_task_end tx_task_end_properties u_props (.clk_sys, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .stat, .tx_go, .cal_go, .rx_on, .sync_search_en, .rssi_poll,
  .task_busy, .irq);

// file: tb/radio_tx_task_end_tb.sv
// Self-checking bench for the transmit task end block
module radio_tx_task_end_tb
  import tx_end_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, evt1_en = 1'b0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, tx_go, cal_go, rx_on, sync_search_en, rssi_poll, task_busy;
  logic [6:0]  channel_frequency;
  logic [7:0]  max_retry_count;
  radio_stat_t base, tmp, stat;
  radio_stat_t lv = '0;
  irq_t        irq, seen;
  int          bad_count = 0, samples_checked = 0, n_go = 0, cyc = 0;
  int          t_end = 0, t_go = 0, t_rx = 0, i, d;
  cause_t      exp_c[5] = '{CAUSE_SEND_QUEUE, CAUSE_LOCK_BUSY, CAUSE_BAD_PARAMETER,
                            CAUSE_BAD_PARAMETER, CAUSE_BAD_COMMAND};
  tx_task_end #(.CAL_STEPS(8)) dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .stat, .tx_go, .cal_go, .rx_on, .sync_search_en,
    .rssi_poll, .channel_frequency, .max_retry_count, .task_busy, .irq);
  radio_side_model u_radio (.clk_sys, .rst_n, .cal_go, .tx_go, .evt1_en, .lv, .stat);
  always #5 clk_sys = ~clk_sys;
  // Cycle stamps of packet starts, ends and listening
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    n_go <= n_go + int'(tx_go === 1'b1);
    if (tx_go === 1'b1) t_go <= cyc;
    if (stat.tx_end === 1'b1) t_end <= cyc;
    if (rx_on === 1'b1 && t_rx == 0) t_rx <= cyc;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Setup then access; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    for (n = 0; n < 50 && pready !== 1'b1; n++)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
    begin
      bad_count++;
      close_out();
    end
  endtask : apb
  task automatic cmd(input logic [7:0] c);
    apb(1'b1, OFS_CMD, {24'h0, c});
  endtask : cmd
  // Collects interrupt pulses until done, then reads the end reason
  task automatic wait_done(input cause_t c);
    int n;
    seen = '0;
    for (n = 0; n < 3000 && seen.done !== 1'b1; n++)
    begin
      @(negedge clk_sys);
      seen = seen | irq;
    end
    if (seen.done !== 1'b1)
    begin
      bad_count++;
      close_out();
    end
    else
    begin
      apb(1'b0, OFS_REASON, 32'h0);
      chk("reason", rd, {28'h0, c});
    end
  endtask : wait_done
  task automatic wait_go(input int k);
    int n;
    for (n = 0; n < 3000 && n_go < k; n++)
      @(negedge clk_sys);
    chk("packet starts", n_go, k);
  endtask : wait_go
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    base = '{q_avail: 1'b1, lock_free: 1'b1, radio_on: 1'b1, rssi_valid: 1'b1,
             rssi: 8'h05, default: '0};
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    lv <= base;
    evt1_en <= 1'b1;
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, OFS_CHAN, 32'hFF);
    apb(1'b1, OFS_RETRY, 32'h1A5);
    apb(1'b0, OFS_CHAN, 32'h0);
    chk("regs", {max_retry_count, 1'b0, channel_frequency, rd[15:0]}, 32'hA57F_007F);
    cmd(CMD_SEND);
    wait_done(CAUSE_SUCCESS);
    apb(1'b1, OFS_CTRL, 32'h3);
    i = n_go;
    cmd(CMD_SEND);
    wait_go(i + 2);
    lv.q_avail <= 1'b0;
    wait_done(CAUSE_SUCCESS);
    lv.q_avail <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_WAIT, 32'h28);
    i = n_go;
    cmd(CMD_SEND);
    wait_go(i + 2);
    chk("wait 40", 32'(t_go - t_end inside {[250:253]}), 32'h1);
    apb(1'b1, OFS_WAIT, 32'h0);
    i = n_go;
    wait_go(i + 2);
    chk("wait 0", 32'(t_go - t_end <= 7), 32'h1);
    cmd(CMD_STOP);
    wait_done(CAUSE_STOPPED);
    // Timer event 2 actions while waiting for event 1
    evt1_en <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, OFS_CTRL, 32'(i << 2));
      cmd(CMD_SEND);
      cmd(CMD_SOFT_EVT2);
      if (i == 1)
        wait_done(CAUSE_STOPPED);
      else
      begin
        if (i != 2) chk("still busy", {31'h0, task_busy}, 32'h1);
        if (i == 0) cmd(CMD_SEND);
        if (i == 3) cmd(CMD_POWER_DOWN);
        wait_done(CAUSE_ABORT);
        chk("abort irq", {31'h0, seen.abort}, 32'h1);
      end
    end
    evt1_en <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h0);
    lv.out_code <= OUT_RETRIES;
    cmd(CMD_SEND);
    wait_done(CAUSE_RETRIES);
    lv.out_code <= OUT_OVERFLOW;
    cmd(CMD_SEND);
    wait_done(CAUSE_RECEIVE_QUEUE);
    chk("full irq", {31'h0, seen.rx_full}, 32'h1);
    // Error ends: queue, lock, parameter, length, unknown command
    for (i = 0; i < 5; i++)
    begin
      tmp = base;
      tmp.q_avail = (i != 0);
      tmp.lock_free = (i != 1);
      tmp.param_bad = (i == 2);
      tmp.len_field = (i == 3) ? 8'h80 : 8'h10;
      tmp.len_mode = LEN_AUTO7;
      d = n_go;
      lv <= tmp;
      cmd(CMD_SEND);
      if (i == 4) cmd(8'h55);
      wait_done(exp_c[i]);
      chk("engine irq", {31'h0, seen.eng_err}, 32'h1);
      if (i == 0) chk("abort irq", {31'h0, seen.abort}, 32'h1);
      if (i == 1) chk("no packet", n_go, d);
    end
    lv <= base;
    apb(1'b1, OFS_LIMIT, 32'h10);
    apb(1'b1, OFS_QUIET, 32'h2);
    i = n_go;
    cmd(CMD_SEND_QUIET);
    wait_go(i + 1);
    chk("quiet start", 32'((t_go - t_rx) inside {[1599:1601]}), 32'h1);
    wait_done(CAUSE_SUCCESS);
    close_out();
  end
endmodule : radio_tx_task_end_tb
